// ==== common/quad_dac_regs.svh ====
`ifndef QUAD_DAC_REGS_SVH
`define QUAD_DAC_REGS_SVH

`define ADDR_DEVICE_CONFIG        4'h3
`define ADDR_OUTPUT_GAIN_SETTING  4'h4
`define ADDR_TRIGGER_COMMAND      4'h5

`define RESET_DEVICE_CONFIG       16'h0000
`define RESET_TRIGGER_COMMAND     5'h00
`define MASK_DEVICE_CONFIG        16'h3f0f
`define MASK_OUTPUT_GAIN_SETTING  16'h010f

`define CFG_ALARM_SOURCE_SELECT   13
`define CFG_ALARM_PIN_MODE        12
`define CFG_CRC_ENABLE            11
`define CFG_EARLY_SERIAL_OUT      10
`define CFG_SERIAL_OUT_DISABLE    9
`define CFG_REFERENCE_SHUTDOWN    8
`define CFG_CHANNEL_SHUTDOWN_MSB  3

`define GAIN_REFERENCE_HALVE      8
`define GAIN_CHANNEL_DOUBLE_MSB   3

`define TRIG_SYNC_LOAD_STROBE     4
`define TRIG_SOFT_RESET_MSB       3
`define SOFT_RESET_CODE           4'ha

`define FRAME_RW_BIT              23
`define FRAME_ADDR_MSB            19
`define FRAME_BITS_PLAIN          6'h18
`define FRAME_BITS_WITH_CRC       6'h20
`define BIT_COUNT_MAX             6'h3f
`define STRAP_LOAD_CYCLES         2'h3

`endif

// ==== common/quad_dac_pkg.sv ====
`default_nettype none
package quad_dac_pkg;
  typedef logic [3:0]  reg_addr_t;
  typedef logic [15:0] reg_word_t;
  typedef logic [23:0] frame_word_t;
endpackage : quad_dac_pkg
`default_nettype wire

// ==== design/pin_sync_edge.sv ====
`timescale 1ns/1ps
`default_nettype none
module pin_sync_edge (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic sys_rst,
  // Asynchronous pin.
  input  wire logic pinIn,
  // Synchronised level and its edges.
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic meta;
  logic stage;
  logic prior;

  // The first stage feeds only the second, so metastability stays contained.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta  <= 1'b0;
      stage <= 1'b0;
      prior <= 1'b0;
    end else begin
      meta  <= pinIn;
      stage <= meta;
      prior <= stage;
    end
  end

  assign level = stage;
  assign rise  = stage & ~prior;
  assign fall  = ~stage & prior;
endmodule : pin_sync_edge
`default_nettype wire

// ==== design/quad_dac_config_gain_trigger_regs.sv ====
// Overview of operation
// - Config bit 13 picks alarm source: clear is CRC error, set is reference alarm.
// - Config bit 12 makes the pin an open-drain low alarm, else push-pull output.
// - Config bit 11 set enables CRC checking of frames; clear disables it.
// - Config bit 10 clear shifts output on SCLK rise; set shifts on fall.
// - Config bit 9 set floats the output; clear drives it while selected.
// - Config bit 8 set shuts down the internal reference.
// - Config bits 3 to 0 each power down the matching channel.
// - Configuration register at address 3, reset zero, reserved bits zero.
// - Gain bit 8 halves the reference; reset value follows its strap pin.
// - Gain bits 3 to 0 give channel gain two; reset follows gain strap.
// - Trigger register at address 5 is write-only, resets zero, bits 4:0.
// - Writing the load strobe updates all synchronous-mode channels together.
// - Writing code 1010 to the reset field restores default register state.
`timescale 1ns/1ps
`default_nettype none
`include "quad_dac_regs.svh"
module quad_dac_config_gain_trigger_regs (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Serial interface pins.
  input  wire logic       sclk,
  input  wire logic       sdi,
  input  wire logic       csN,
  output logic            sdoOut,
  output logic            sdoOe,
  // Strap and analog status pins.
  input  wire logic       refdivStrap,
  input  wire logic       gainStrap,
  input  wire logic       refAlarm,
  // Companion logic on the same clock.
  input  wire logic       frameCrcGood,
  input  wire logic [3:0] syncModeEnable,
  // Analog and channel controls.
  output logic            crcCheckEnable,
  output logic            referenceShutdown,
  output logic [3:0]      channelShutdown,
  output logic            referenceHalve,
  output logic [3:0]      channelDoubleGain,
  output logic [3:0]      channelLoad,
  output logic            deviceSoftReset
);
  logic                      sclkLevel;
  logic                      sclkRise;
  logic                      sclkFall;
  logic                      sdiLevel;
  logic                      csNLevel;
  logic                      csNRise;
  logic                      csNFall;
  logic                      selLevel;
  logic                      selRise;
  logic                      selFall;
  logic                      refdivLevel;
  logic                      gainLevel;
  logic                      refAlarmLevel;
  logic [31:0]               shiftIn;
  logic [5:0]                bitCount;
  logic [23:0]               txShift;
  logic [23:0]               readBuf;
  logic [15:0]               deviceConfig;
  logic [15:0]               outputGainSetting;
  logic [4:0]                triggerCommand;
  logic [1:0]                strapCount;
  logic                      crcError;
  logic                      crcEn;
  logic                      frameLenOk;
  logic                      frameGood;
  logic                      writeOk;
  logic                      readOk;
  logic                      softResetHit;
  logic                      strapLoad;
  logic                      alarmActive;
  logic                      shiftOutEdge;
  quad_dac_pkg::frame_word_t frameWord;
  quad_dac_pkg::reg_addr_t   frameAddr;
  quad_dac_pkg::reg_word_t   frameData;
  quad_dac_pkg::reg_word_t   readValue;

  pin_sync_edge uSclk (
    .clk(clk), .sys_rst(sys_rst), .pinIn(sclk),
    .level(sclkLevel), .rise(sclkRise), .fall(sclkFall));
  pin_sync_edge uSdi (
    .clk(clk), .sys_rst(sys_rst), .pinIn(sdi),
    .level(sdiLevel), .rise(), .fall());
  // The select pin idles high, so it is synchronised inverted: the reset
  // level then matches the idle level and no false edge follows reset.
  pin_sync_edge uCs (
    .clk(clk), .sys_rst(sys_rst), .pinIn(~csN),
    .level(selLevel), .rise(selRise), .fall(selFall));
  assign csNLevel = ~selLevel;
  assign csNRise  = selFall;
  assign csNFall  = selRise;
  pin_sync_edge uRefdiv (
    .clk(clk), .sys_rst(sys_rst), .pinIn(refdivStrap),
    .level(refdivLevel), .rise(), .fall());
  pin_sync_edge uGain (
    .clk(clk), .sys_rst(sys_rst), .pinIn(gainStrap),
    .level(gainLevel), .rise(), .fall());
  pin_sync_edge uRefAlarm (
    .clk(clk), .sys_rst(sys_rst), .pinIn(refAlarm),
    .level(refAlarmLevel), .rise(), .fall());

  // Data bits are taken on the SCLK falling edge while selected.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      shiftIn  <= 32'h0000_0000;
      bitCount <= 6'h00;
    end else if (csNFall) begin
      bitCount <= 6'h00;
    end else if (sclkFall && !csNLevel) begin
      shiftIn <= {shiftIn[30:0], sdiLevel};
      if (bitCount != `BIT_COUNT_MAX) begin
        bitCount <= bitCount + 6'h01;
      end
    end
  end

  assign crcEn      = deviceConfig[`CFG_CRC_ENABLE];
  // A CRC frame carries eight check bits behind the command word.
  assign frameWord  = crcEn ? shiftIn[31:8] : shiftIn[23:0];
  assign frameLenOk = crcEn ? (bitCount == `FRAME_BITS_WITH_CRC)
                            : (bitCount == `FRAME_BITS_PLAIN);
  assign frameGood  = csNRise && frameLenOk
                      && (!crcEn || frameCrcGood);
  assign frameAddr  = frameWord[`FRAME_ADDR_MSB -: 4];
  assign frameData  = frameWord[15:0];
  assign writeOk    = frameGood && !frameWord[`FRAME_RW_BIT];
  assign readOk     = frameGood && frameWord[`FRAME_RW_BIT];
  assign softResetHit = writeOk && (frameAddr == `ADDR_TRIGGER_COMMAND)
      && (frameData[`TRIG_SOFT_RESET_MSB -: 4] == `SOFT_RESET_CODE);
  assign strapLoad  = (strapCount != `STRAP_LOAD_CYCLES);

  // Straps are read after release, once their synchronisers have settled.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      strapCount <= 2'h0;
    end else if (softResetHit) begin
      strapCount <= 2'h0;
    end else if (strapLoad) begin
      strapCount <= strapCount + 2'h1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      deviceConfig <= `RESET_DEVICE_CONFIG;
    end else if (softResetHit) begin
      deviceConfig <= `RESET_DEVICE_CONFIG;
    end else if (writeOk && frameAddr == `ADDR_DEVICE_CONFIG) begin
      deviceConfig <= frameData & `MASK_DEVICE_CONFIG;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      outputGainSetting <= 16'h0000;
    end else if (strapLoad) begin
      outputGainSetting <= 16'h0000;
      outputGainSetting[`GAIN_REFERENCE_HALVE] <= refdivLevel;
      outputGainSetting[`GAIN_CHANNEL_DOUBLE_MSB -: 4] <= {4{gainLevel}};
    end else if (writeOk && frameAddr == `ADDR_OUTPUT_GAIN_SETTING) begin
      outputGainSetting <= frameData & `MASK_OUTPUT_GAIN_SETTING;
    end
  end

  // The trigger holds a write for one cycle only, so it never reads back.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      triggerCommand <= `RESET_TRIGGER_COMMAND;
    end else if (writeOk && frameAddr == `ADDR_TRIGGER_COMMAND) begin
      triggerCommand <= frameData[4:0];
    end else begin
      triggerCommand <= `RESET_TRIGGER_COMMAND;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      channelLoad     <= 4'h0;
      deviceSoftReset <= 1'b0;
    end else begin
      channelLoad     <= triggerCommand[`TRIG_SYNC_LOAD_STROBE]
                         ? syncModeEnable : 4'h0;
      deviceSoftReset <= (triggerCommand[`TRIG_SOFT_RESET_MSB -: 4]
                          == `SOFT_RESET_CODE);
    end
  end

  // A bad check sets the flag; only a later good frame clears it.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      crcError <= 1'b0;
    end else if (csNRise && frameLenOk && crcEn && !frameCrcGood) begin
      crcError <= 1'b1;
    end else if (frameGood) begin
      crcError <= 1'b0;
    end
  end

  always_comb begin
    readValue = 16'h0000;
    unique case (frameAddr)
      `ADDR_DEVICE_CONFIG:       readValue = deviceConfig;
      `ADDR_OUTPUT_GAIN_SETTING: readValue = outputGainSetting;
      default:                   readValue = 16'h0000;
    endcase
  end

  assign shiftOutEdge = deviceConfig[`CFG_EARLY_SERIAL_OUT]
                        ? sclkFall : sclkRise;

  // A read frame is answered during the following frame.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      readBuf <= 24'h00_0000;
      txShift <= 24'h00_0000;
    end else begin
      if (readOk) begin
        readBuf <= {frameWord[23:16], readValue};
      end
      if (csNFall) begin
        txShift <= readBuf;
      end else if (shiftOutEdge && !csNLevel) begin
        txShift <= {txShift[22:0], 1'b0};
      end
    end
  end

  assign alarmActive = deviceConfig[`CFG_ALARM_SOURCE_SELECT]
                       ? refAlarmLevel : crcError;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sdoOut <= 1'b0;
      sdoOe  <= 1'b0;
    end else if (deviceConfig[`CFG_ALARM_PIN_MODE]) begin
      sdoOut <= 1'b0;
      sdoOe  <= alarmActive;
    end else begin
      sdoOut <= txShift[23];
      sdoOe  <= !deviceConfig[`CFG_SERIAL_OUT_DISABLE] && !csNLevel;
    end
  end

  assign crcCheckEnable    = deviceConfig[`CFG_CRC_ENABLE];
  assign referenceShutdown = deviceConfig[`CFG_REFERENCE_SHUTDOWN];
  assign channelShutdown   = deviceConfig[`CFG_CHANNEL_SHUTDOWN_MSB -: 4];
  assign referenceHalve    = outputGainSetting[`GAIN_REFERENCE_HALVE];
  assign channelDoubleGain = outputGainSetting[`GAIN_CHANNEL_DOUBLE_MSB -: 4];
endmodule : quad_dac_config_gain_trigger_regs
`default_nettype wire

// ==== tb/quad_dac_regs_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module quad_dac_regs_checker (
  // Clock, reset and pins.
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       csN,
  input wire logic       sdoOut,
  input wire logic       sdoOe,
  input wire logic [3:0] syncModeEnable,
  // Controls.
  input wire logic       crcCheckEnable,
  input wire logic       referenceShutdown,
  input wire logic [3:0] channelShutdown,
  input wire logic       referenceHalve,
  input wire logic [3:0] channelDoubleGain,
  input wire logic [3:0] channelLoad,
  input wire logic       deviceSoftReset
);
  logic [3:0] csHighCnt;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Counts how long select has been high, saturating so it never wraps.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) csHighCnt <= 4'h0;
    else if (!csN) csHighCnt <= 4'h0;
    else if (csHighCnt != 4'hf) csHighCnt <= csHighCnt + 4'h1;
  end
  a_cfg_quiet: assert property ($changed({crcCheckEnable,
    referenceShutdown, channelShutdown}) |-> csN)
    else $error("config moved inside a frame");
  a_gain_quiet: assert property ($changed(channelDoubleGain) |-> csN)
    else $error("gain moved inside a frame");
  a_halve_quiet: assert property ($changed(referenceHalve) |-> csN)
    else $error("halve moved inside a frame");
  a_load_pulse: assert property (|channelLoad |=> channelLoad == 4'h0)
    else $error("load pulse too long");
  a_load_mask: assert property (|channelLoad |->
    (channelLoad & ~syncModeEnable) == 4'h0)
    else $error("load outside sync mask");
  a_reset_pulse: assert property (deviceSoftReset |=> !deviceSoftReset)
    else $error("soft reset pulse too long");
  a_reset_clears: assert property (deviceSoftReset |-> !crcCheckEnable &&
    !referenceShutdown && channelShutdown == 4'h0)
    else $error("soft reset left config set");
  a_sdo_select: assert property (sdoOe && sdoOut |-> csHighCnt < 4'h6)
    else $error("output driven high while deselected");
  cover property (|channelLoad);
  cover property (deviceSoftReset);
  cover property (sdoOe && !csN);
endmodule : quad_dac_regs_checker
bind quad_dac_config_gain_trigger_regs quad_dac_regs_checker chk (
  .clk(clk), .sys_rst(sys_rst), .csN(csN), .sdoOut(sdoOut), .sdoOe(sdoOe),
  .syncModeEnable(syncModeEnable), .crcCheckEnable(crcCheckEnable),
  .referenceShutdown(referenceShutdown), .channelShutdown(channelShutdown),
  .referenceHalve(referenceHalve), .channelDoubleGain(channelDoubleGain),
  .channelLoad(channelLoad), .deviceSoftReset(deviceSoftReset));
`default_nettype wire

// ==== tb/spi_master_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
  input  wire logic clk,
  input  wire logic sdoLine,
  output logic      sclk,
  output logic      sdi,
  output logic      csN
);
  logic [31:0] rxWord;
  initial begin
    sclk = 1'b0;
    sdi = 1'b0;
    csN = 1'b1;
  end
  // The clock stands low between frames; 8 cycles a half keeps 40 ns, an 80 ns period.
  task automatic xfer(input logic [31:0] w, input int n);
    rxWord = 32'h0000_0000;
    @(posedge clk) csN <= 1'b0;
    repeat (8) @(posedge clk);
    for (int i = n - 1; i >= 0; i--) begin
      rxWord = {rxWord[30:0], sdoLine};
      sdi <= w[i];
      sclk <= 1'b1;
      repeat (8) @(posedge clk);
      sclk <= 1'b0;
      repeat (8) @(posedge clk);
    end
    csN <= 1'b1;
    sdi <= ~sdi;
    repeat (16) @(posedge clk);
  endtask : xfer
endmodule : spi_master_model
`default_nettype wire

// ==== tb/quad_dac_config_gain_trigger_regs_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin \
  miscompares++; $display("BAD %s exp %h got %h", n, e, a); end end
module quad_dac_config_gain_trigger_regs_tb;
  logic       clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       refdivStrap = 1'b1;
  logic       gainStrap = 1'b1;
  logic       refAlarm = 1'b0;
  logic       frameCrcGood = 1'b1;
  logic [3:0] syncModeEnable = 4'h6;
  logic [3:0] loadAcc = 4'h0;
  logic       oeAcc = 1'b0;
  logic       sclk, sdi, csN, sdoOut, sdoOe, sdoLine, crcCheckEnable;
  logic       referenceShutdown, referenceHalve, deviceSoftReset;
  logic [3:0] channelShutdown, channelDoubleGain, channelLoad;
  int         rstCnt = 0, miscompares = 0, tests_run = 0;
  always #2.5 clk = ~clk;
  // The shared pin has a pull-up, so a released pin reads high.
  assign sdoLine = sdoOe ? sdoOut : 1'b1;
  always @(posedge clk) begin
    loadAcc <= loadAcc | channelLoad;
    oeAcc <= oeAcc | sdoOe;
    rstCnt <= rstCnt + int'(deviceSoftReset);
  end
  spi_master_model mdl (.clk(clk), .sdoLine(sdoLine), .sclk(sclk),
    .sdi(sdi), .csN(csN));
  quad_dac_config_gain_trigger_regs dut (.clk(clk), .sys_rst(sys_rst),
    .sclk(sclk), .sdi(sdi), .csN(csN), .sdoOut(sdoOut), .sdoOe(sdoOe),
    .refdivStrap(refdivStrap), .gainStrap(gainStrap), .refAlarm(refAlarm),
    .frameCrcGood(frameCrcGood), .syncModeEnable(syncModeEnable),
    .crcCheckEnable(crcCheckEnable), .referenceShutdown(referenceShutdown),
    .channelShutdown(channelShutdown), .referenceHalve(referenceHalve),
    .channelDoubleGain(channelDoubleGain), .channelLoad(channelLoad),
    .deviceSoftReset(deviceSoftReset));
  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run
  task automatic clr;
    @(negedge clk);
    loadAcc = 4'h0;
    oeAcc = 1'b0;
    rstCnt = 0;
  endtask : clr
  task automatic wr(input logic [3:0] a, input logic [15:0] d, input int n);
    if (n == 32) mdl.xfer({4'h0, a, d, 8'h5A}, 32);
    else mdl.xfer({8'h00, 4'h0, a, d}, 24);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    mdl.xfer({8'h00, 4'h8, a, 16'h0000}, 24);
    mdl.xfer(32'h0000_0000, 24);
    `CHK("readback", {4'h8, a, e}, mdl.rxWord[23:0])
  endtask : rd
  task automatic do_reset;
    @(posedge clk) sys_rst <= 1'b1;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : do_reset
  task automatic t_reset;
    `CHK("cfg", 6'h00, {crcCheckEnable, referenceShutdown, channelShutdown})
    `CHK("gain", 5'h1F, {referenceHalve, channelDoubleGain})
  endtask : t_reset
  task automatic t_cfg;
    wr(4'h3, 16'hC1FA, 24);
    `CHK("cfg", 6'h1A, {crcCheckEnable, referenceShutdown, channelShutdown})
    rd(4'h3, 16'h010A);
    wr(4'h3, 16'h0400, 24);
    rd(4'h3, 16'h0400);
  endtask : t_cfg
  task automatic t_gain;
    wr(4'h4, 16'hFE05, 24);
    `CHK("gain", 5'h05, {referenceHalve, channelDoubleGain})
    rd(4'h4, 16'h0005);
  endtask : t_gain
  task automatic t_crc;
    wr(4'h3, 16'h1800, 24);
    `CHK("crc on", 1'b1, crcCheckEnable)
    wr(4'h3, 16'h0000, 24);
    `CHK("short frame", 1'b1, crcCheckEnable)
    @(posedge clk) frameCrcGood <= 1'b0;
    wr(4'h3, 16'h0000, 32);
    `CHK("bad crc", 1'b1, crcCheckEnable)
    `CHK("crc alarm", 1'b0, sdoLine)
    @(posedge clk) frameCrcGood <= 1'b1;
    wr(4'h3, 16'h0000, 32);
    `CHK("crc off", 1'b0, crcCheckEnable)
  endtask : t_crc
  task automatic t_trig;
    wr(4'h3, 16'h0103, 24);
    clr;
    wr(4'h5, 16'h0015, 24);
    `CHK("load", 4'h6, loadAcc)
    `CHK("no reset", 0, rstCnt)
    `CHK("cfg kept", 1'b1, referenceShutdown)
    rd(4'h5, 16'h0000);
    @(posedge clk) syncModeEnable <= 4'h9;
    clr;
    wr(4'h5, 16'h001A, 24);
    `CHK("reset", 1, rstCnt)
    `CHK("cfg", 6'h00, {crcCheckEnable, referenceShutdown, channelShutdown})
    `CHK("gain", 5'h1F, {referenceHalve, channelDoubleGain})
    `CHK("load", 4'h9, loadAcc)
  endtask : t_trig
  task automatic t_sdo;
    clr;
    wr(4'h3, 16'h0200, 24);
    `CHK("driven", 1'b1, oeAcc)
    clr;
    wr(4'h3, 16'h3000, 24);
    `CHK("disabled", 1'b0, oeAcc)
    @(posedge clk) refAlarm <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK("ref alarm", 1'b0, sdoLine)
    refAlarm <= 1'b0;
    repeat (8) @(posedge clk);
    `CHK("alarm clear", 1'b1, sdoLine)
    wr(4'h3, 16'h1000, 24);
    refAlarm <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK("crc source", 1'b1, sdoLine)
    wr(4'h3, 16'h0000, 24);
  endtask : t_sdo
  initial begin
    do_reset;
    t_reset;
    t_cfg;
    do_reset;
    t_reset;
    t_gain;
    t_crc;
    t_trig;
    t_sdo;
    complete_run;
  end
  initial begin
    #400_000;
    miscompares++;
    complete_run;
  end
endmodule : quad_dac_config_gain_trigger_regs_tb
`default_nettype wire
